// *** hw/rxm_pkg.sv ***
// Package for the receive MAC configuration and status bank.
// Assumes a byte-wide receive stream and APB register access with 32-bit data.
package rxm_pkg;

    // ------------------------------------------------------------
    // Register map (word index; byte address is index * 4)
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 12;
    localparam int unsigned ADDR_LSB = 2;
    localparam logic [IDX_W-1:0] IDX_TX_CTRL = 12'h40A;
    localparam logic [IDX_W-1:0] IDX_REV_ID = 12'h500;
    localparam logic [IDX_W-1:0] IDX_SCRATCH = 12'h501;
    localparam logic [IDX_W-1:0] IDX_NAME_LO = 12'h502;
    localparam logic [IDX_W-1:0] IDX_NAME_MID = 12'h503;
    localparam logic [IDX_W-1:0] IDX_NAME_HI = 12'h504;
    localparam logic [IDX_W-1:0] IDX_MAX_LEN = 12'h506;
    localparam logic [IDX_W-1:0] IDX_CRC_FWD = 12'h507;
    localparam logic [IDX_W-1:0] IDX_FAULT = 12'h508;
    localparam logic [IDX_W-1:0] IDX_RX_CTRL = 12'h50A;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h50C;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h50D;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned TX_VLAN_DIS_BIT = 1;
    localparam int unsigned RX_STRICT_PRE_BIT = 4;
    localparam int unsigned CRC_FWD_BIT = 0;
    localparam int unsigned MAX_LEN_W = 16;
    localparam logic [MAX_LEN_W-1:0] MAX_LEN_RST = 16'h2580;
    localparam logic [DATA_W-1:0] SCRATCH_RST = 32'h0000_0000;
    localparam logic VLAN_DIS_RST = 1'b0;
    localparam logic CRC_FWD_RST = 1'b0;
    localparam logic STRICT_PRE_RST = 1'b1;

    // Error vector and interrupt bits
    localparam int unsigned ERR_W = 4;
    localparam int unsigned ERR_SFD = 0;
    localparam int unsigned ERR_FCS = 1;
    localparam int unsigned ERR_RUNT = 2;
    localparam int unsigned ERR_OVERSIZE = 3;
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_FAULT_CHG = 4;
    localparam int unsigned FAULT_W = 2;
    localparam int unsigned FAULT_LOCAL = 0;
    localparam int unsigned FAULT_REMOTE = 1;

    // ------------------------------------------------------------
    // Framing constants
    // ------------------------------------------------------------
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hD5;
    localparam logic [3:0] PRE_LEN = 4'h8;
    localparam int unsigned FCS_LEN = 4;
    localparam logic [MAX_LEN_W-1:0] MIN_FRAME = 16'h0040;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;

    // ------------------------------------------------------------
    // Stream carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [7:0] data;
    } rxm_beat_t;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [7:0] data;
        logic [ERR_W-1:0] err;
    } rxm_client_t;

endpackage

// *** hw/rxm_crc32_step.sv ***
// One-byte step of the reflected frame check sequence polynomial.
// Purely combinational; the caller holds the running remainder.
`timescale 1ns/100ps
module rxm_crc32_step (
    // Running remainder
    input wire logic [31:0] crc_in,
    // New byte, least significant bit first on the wire
    input wire logic [7:0] data_in,
    // Updated remainder
    output logic [31:0] crc_out
);

    // ------------------------------------------------------------
    // Bitwise update
    // ------------------------------------------------------------
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ rxm_pkg::CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction

    assign crc_out = crc_byte(crc_in, data_in);

endmodule

// *** hw/rxm_csr_bank.sv ***
// Receive MAC configuration and status bank with its byte-wide frame checker.
// Assumes an APB master on the register side and a PCS that flags fault
// sequences as levels; the receive stream carries preamble and SFD first.
`timescale 1ns/100ps
module rxm_csr_bank #(
    parameter int unsigned ADDR_W = 16,
    // Identity values below are arbitrary
    parameter logic [31:0] REV_ID = 32'h0001_0000,
    parameter logic [31:0] NAME_LO = 32'h5258_4D41,
    parameter logic [31:0] NAME_MID = 32'h4352_5831,
    parameter logic [15:0] NAME_HI = 16'h5253
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive stream from the PCS side
    input wire rxm_pkg::rxm_beat_t rx_in,
    // Receive client stream
    output rxm_pkg::rxm_client_t rx_out,
    // Fault sequence detection and link mode
    input wire logic fault_local_seen,
    input wire logic fault_remote_seen,
    input wire logic link_unidir_en,
    // Controls and interrupt
    output logic vlan_detect_disable,
    output logic irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < rxm_pkg::IDX_W + rxm_pkg::ADDR_LSB) begin : g_bad_addr
        $error("ADDR_W too narrow for the register map");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic vlan_dis;
        logic [31:0] scratch;
        logic [rxm_pkg::MAX_LEN_W-1:0] max_len;
        logic crc_fwd;
        logic strict_pre;
        logic [rxm_pkg::IRQ_W-1:0] irq_stat;
        logic [rxm_pkg::IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
        logic [rxm_pkg::FAULT_W-1:0] fault;
        logic in_frame;
        logic [3:0] pre_cnt;
        logic pre_bad;
        logic [rxm_pkg::MAX_LEN_W-1:0] len;
        logic [31:0] crc;
        logic [2:0] hold_cnt;
        logic [rxm_pkg::FCS_LEN-1:0][7:0] hold;
        logic sop_pend;
        rxm_pkg::rxm_client_t out;
    } rxm_state_t;

    rxm_state_t st_ff;
    rxm_state_t nxt_st;
    logic [31:0] crc_step;

    rxm_crc32_step u_crc (
        .crc_in(st_ff.crc),
        .data_in(rx_in.data),
        .crc_out(crc_step)
    );

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [rxm_pkg::IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
        return a[rxm_pkg::ADDR_LSB +: rxm_pkg::IDX_W];
    endfunction

    function automatic logic is_mapped(input logic [rxm_pkg::IDX_W-1:0] i);
        logic hit;
        hit = 1'b0;
        case (i)
            rxm_pkg::IDX_TX_CTRL,
            rxm_pkg::IDX_REV_ID,
            rxm_pkg::IDX_SCRATCH,
            rxm_pkg::IDX_NAME_LO,
            rxm_pkg::IDX_NAME_MID,
            rxm_pkg::IDX_NAME_HI,
            rxm_pkg::IDX_MAX_LEN,
            rxm_pkg::IDX_CRC_FWD,
            rxm_pkg::IDX_FAULT,
            rxm_pkg::IDX_RX_CTRL,
            rxm_pkg::IDX_IRQ_STAT,
            rxm_pkg::IDX_IRQ_MASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Byte-enable merge shared by every writable word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] read_word(input logic [rxm_pkg::IDX_W-1:0] i,
                                              input rxm_state_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (i)
            rxm_pkg::IDX_TX_CTRL: r[rxm_pkg::TX_VLAN_DIS_BIT] = s.vlan_dis;
            rxm_pkg::IDX_REV_ID: r = REV_ID;
            rxm_pkg::IDX_SCRATCH: r = s.scratch;
            rxm_pkg::IDX_NAME_LO: r = NAME_LO;
            rxm_pkg::IDX_NAME_MID: r = NAME_MID;
            rxm_pkg::IDX_NAME_HI: r = {16'h0000, NAME_HI};
            rxm_pkg::IDX_MAX_LEN: r[rxm_pkg::MAX_LEN_W-1:0] = s.max_len;
            rxm_pkg::IDX_CRC_FWD: r[rxm_pkg::CRC_FWD_BIT] = s.crc_fwd;
            rxm_pkg::IDX_FAULT: r[rxm_pkg::FAULT_W-1:0] = s.fault;
            rxm_pkg::IDX_RX_CTRL: r[rxm_pkg::RX_STRICT_PRE_BIT] = s.strict_pre;
            rxm_pkg::IDX_IRQ_STAT: r[rxm_pkg::IRQ_W-1:0] = s.irq_stat;
            rxm_pkg::IDX_IRQ_MASK: r[rxm_pkg::IRQ_W-1:0] = s.irq_mask;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic apb_setup;
    logic apb_write;
    logic [rxm_pkg::IDX_W-1:0] idx;
    logic [31:0] wmerged;
    logic [rxm_pkg::IRQ_W-1:0] irq_set;
    logic [rxm_pkg::IRQ_W-1:0] irq_clr;
    logic [rxm_pkg::FAULT_W-1:0] fault_now;
    logic [rxm_pkg::MAX_LEN_W-1:0] len_new;
    logic [rxm_pkg::ERR_W-1:0] err_now;

    assign idx = word_idx(paddr);
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && is_mapped(idx);

    always_comb begin
        nxt_st = st_ff;
        wmerged = 32'h0000_0000;
        irq_set = '0;
        irq_clr = '0;
        fault_now = '0;
        len_new = st_ff.len;
        err_now = '0;

        // Read data is captured in the setup cycle so prdata comes from a flop
        if (apb_setup) begin
            nxt_st.rdata = read_word(idx, st_ff);
        end

        // Register writes, reserved bits dropped by taking only field slices
        if (apb_write) begin
            case (idx)
                rxm_pkg::IDX_TX_CTRL: begin
                    wmerged = merge({30'h0, st_ff.vlan_dis, 1'b0}, pwdata, pstrb);
                    nxt_st.vlan_dis = wmerged[rxm_pkg::TX_VLAN_DIS_BIT];
                end
                rxm_pkg::IDX_SCRATCH: begin
                    nxt_st.scratch = merge(st_ff.scratch, pwdata, pstrb);
                end
                rxm_pkg::IDX_MAX_LEN: begin
                    wmerged = merge({16'h0000, st_ff.max_len}, pwdata, pstrb);
                    nxt_st.max_len = wmerged[rxm_pkg::MAX_LEN_W-1:0];
                end
                rxm_pkg::IDX_CRC_FWD: begin
                    wmerged = merge({31'h0, st_ff.crc_fwd}, pwdata, pstrb);
                    nxt_st.crc_fwd = wmerged[rxm_pkg::CRC_FWD_BIT];
                end
                rxm_pkg::IDX_RX_CTRL: begin
                    wmerged = merge({27'h0, st_ff.strict_pre, 4'h0}, pwdata, pstrb);
                    nxt_st.strict_pre = wmerged[rxm_pkg::RX_STRICT_PRE_BIT];
                end
                rxm_pkg::IDX_IRQ_STAT: begin
                    wmerged = merge(32'h0000_0000, pwdata, pstrb);
                    irq_clr = wmerged[rxm_pkg::IRQ_W-1:0];
                end
                rxm_pkg::IDX_IRQ_MASK: begin
                    wmerged = merge({27'h0, st_ff.irq_mask}, pwdata, pstrb);
                    nxt_st.irq_mask = wmerged[rxm_pkg::IRQ_W-1:0];
                end
                default: wmerged = 32'h0000_0000;
            endcase
        end

        // Fault status: bidirectional hides remote behind local
        if (link_unidir_en) begin
            fault_now[rxm_pkg::FAULT_LOCAL] = fault_local_seen;
            fault_now[rxm_pkg::FAULT_REMOTE] = fault_remote_seen;
        end else begin
            fault_now[rxm_pkg::FAULT_LOCAL] = fault_local_seen;
            fault_now[rxm_pkg::FAULT_REMOTE] = fault_remote_seen && !fault_local_seen;
        end
        nxt_st.fault = fault_now;
        if (fault_now != st_ff.fault) begin
            irq_set[rxm_pkg::IRQ_FAULT_CHG] = 1'b1;
        end

        // Client stream defaults: one-cycle beats, data held
        nxt_st.out.valid = 1'b0;
        nxt_st.out.sop = 1'b0;
        nxt_st.out.eop = 1'b0;
        nxt_st.out.err = '0;

        if (rx_in.valid) begin
            if (rx_in.sop) begin
                // First preamble byte opens a frame; a new sop aborts an open one
                nxt_st.in_frame = !rx_in.eop;
                nxt_st.pre_cnt = 4'h1;
                nxt_st.pre_bad = st_ff.strict_pre && (rx_in.data != rxm_pkg::PRE_BYTE);
                nxt_st.len = '0;
                nxt_st.crc = rxm_pkg::CRC_INIT;
                nxt_st.hold_cnt = 3'h0;
                nxt_st.sop_pend = 1'b1;
            end else if (st_ff.in_frame && st_ff.pre_cnt < rxm_pkg::PRE_LEN) begin
                nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
                if (st_ff.pre_cnt == rxm_pkg::PRE_LEN - 4'h1) begin
                    // SFD is always checked, preamble bytes only when strict
                    if (rx_in.data != rxm_pkg::SFD_BYTE) begin
                        nxt_st.pre_bad = 1'b1;
                    end
                end else if (st_ff.strict_pre && rx_in.data != rxm_pkg::PRE_BYTE) begin
                    nxt_st.pre_bad = 1'b1;
                end
                // End inside the preamble drops the frame silently
                if (rx_in.eop) begin
                    nxt_st.in_frame = 1'b0;
                end
            end else if (st_ff.in_frame) begin
                if (st_ff.len != '1) begin
                    len_new = st_ff.len + 16'h0001;
                end
                nxt_st.len = len_new;
                nxt_st.crc = crc_step;
                if (st_ff.crc_fwd) begin
                    nxt_st.out.valid = 1'b1;
                    nxt_st.out.data = rx_in.data;
                    nxt_st.out.sop = st_ff.sop_pend;
                    nxt_st.out.eop = rx_in.eop;
                    nxt_st.sop_pend = 1'b0;
                end else begin
                    // Four-byte delay keeps the FCS out of the client stream
                    nxt_st.hold = {st_ff.hold[rxm_pkg::FCS_LEN-2:0], rx_in.data};
                    if (st_ff.hold_cnt == 3'(rxm_pkg::FCS_LEN)) begin
                        nxt_st.out.valid = 1'b1;
                        nxt_st.out.data = st_ff.hold[rxm_pkg::FCS_LEN-1];
                        nxt_st.out.sop = st_ff.sop_pend;
                        nxt_st.out.eop = rx_in.eop;
                        nxt_st.sop_pend = 1'b0;
                    end else begin
                        nxt_st.hold_cnt = st_ff.hold_cnt + 3'h1;
                    end
                end
                if (rx_in.eop) begin
                    nxt_st.in_frame = 1'b0;
                    err_now[rxm_pkg::ERR_SFD] = st_ff.pre_bad;
                    err_now[rxm_pkg::ERR_FCS] = crc_step != rxm_pkg::CRC_RESIDUE;
                    err_now[rxm_pkg::ERR_RUNT] = len_new < rxm_pkg::MIN_FRAME;
                    err_now[rxm_pkg::ERR_OVERSIZE] = len_new > st_ff.max_len;
                    nxt_st.out.err = err_now;
                    irq_set[rxm_pkg::ERR_W-1:0] = err_now;
                end
            end
        end

        // Sticky status: a set in the clearing cycle survives
        nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_set;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.vlan_dis <= rxm_pkg::VLAN_DIS_RST;
            st_ff.scratch <= rxm_pkg::SCRATCH_RST;
            st_ff.max_len <= rxm_pkg::MAX_LEN_RST;
            st_ff.crc_fwd <= rxm_pkg::CRC_FWD_RST;
            st_ff.strict_pre <= rxm_pkg::STRICT_PRE_RST;
            st_ff.crc <= rxm_pkg::CRC_INIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(idx);
    assign prdata = st_ff.rdata;
    assign rx_out = st_ff.out;
    assign vlan_detect_disable = st_ff.vlan_dis;
    assign irq = st_ff.irq;

endmodule

// *** tb/rxm_csr_properties.sv ***
// Checker for the receive MAC register bank, bound to its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module rxm_csr_properties #(
    parameter int unsigned ADDR_W = 16,
    parameter logic [31:0] REV_ID = 32'h0000_0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Streams and controls
    input wire rxm_pkg::rxm_beat_t rx_in,
    input wire rxm_pkg::rxm_client_t rx_out,
    input wire logic vlan_detect_disable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [11:0] idx);
        psel && !penable && !pwrite && paddr[13:2] == idx;
    endsequence
    sequence s_tx_wr;
        psel && penable && pwrite && pstrb[0] && paddr[13:2] == rxm_pkg::IDX_TX_CTRL;
    endsequence
    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    property p_unmapped; psel && penable && paddr[13:2] == 12'h505 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no pslverr on hole");
    property p_vlan_wr; s_tx_wr |=> vlan_detect_disable == $past(pwdata[1]); endproperty
    a_vlan_wr: assert property (p_vlan_wr) else $error("vlan bit not written");
    property p_vlan_hold; !(psel && penable && pwrite) |=> $stable(vlan_detect_disable); endproperty
    a_vlan_hold: assert property (p_vlan_hold) else $error("vlan bit moved");
    property p_err_eop; rx_out.err != 4'h0 |-> rx_out.valid && rx_out.eop; endproperty
    a_err_eop: assert property (p_err_eop) else $error("error off eop beat");
    property p_follow; rx_out.valid |-> $past(rx_in.valid); endproperty
    a_follow: assert property (p_follow) else $error("beat without input");
    property p_sop_quiet; rx_in.valid && rx_in.sop |=> !rx_out.valid; endproperty
    a_sop_quiet: assert property (p_sop_quiet) else $error("beat for preamble");
    property p_rev; s_rd(rxm_pkg::IDX_REV_ID) |=> prdata == REV_ID; endproperty
    a_rev: assert property (p_rev) else $error("revision word wrong");
    property p_name_hi; s_rd(rxm_pkg::IDX_NAME_HI) |=> prdata[31:16] == 16'h0000; endproperty
    a_name_hi: assert property (p_name_hi) else $error("ident top not zero");
endmodule
bind rxm_csr_bank rxm_csr_properties #(.ADDR_W(ADDR_W), .REV_ID(REV_ID)) i_rxm_csr_properties (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .rx_in(rx_in),
    .rx_out(rx_out), .vlan_detect_disable(vlan_detect_disable));

// *** tb/rxm_client_model.sv ***
// Client-side model: counts beats of a frame and keeps its error vector.
// Assumes no backpressure on the client stream.
`timescale 1ns/100ps
module rxm_client_model (
    // Clock
    input wire logic clk,
    // Client stream
    input wire rxm_pkg::rxm_client_t rx_out
);
    int beats = 0;
    logic [3:0] last_err = 4'h0;
    always @(posedge clk) begin
        if (rx_out.valid) begin
            beats = rx_out.sop ? 1 : beats + 1;
            if (rx_out.eop) last_err = rx_out.err;
        end
    end
endmodule

// *** tb/tb_rxm_csr_bank.sv ***
// Self-checking bench for the receive MAC register bank.
// Assumes the client model sits on the client stream.
`timescale 1ns/100ps
module tb_rxm_csr_bank;
    // Identity values are arbitrary
    localparam logic [31:0] REV = 32'h0102_0304;
    localparam logic [31:0] NLO = 32'h6162_6364;
    localparam logic [31:0] NMID = 32'h6566_6768;
    localparam logic [15:0] NHI = 16'h696A;
    typedef struct packed {logic [11:0] idx; logic [31:0] wd; logic [31:0] ex; logic er;} rxm_row_t;
    rxm_row_t rows [12] = '{
        '{rxm_pkg::IDX_TX_CTRL, 32'hFFFF_FFFF, 32'h0000_0002, 1'b0},
        '{rxm_pkg::IDX_SCRATCH, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0},
        '{rxm_pkg::IDX_REV_ID, 32'hFFFF_FFFF, REV, 1'b0},
        '{rxm_pkg::IDX_NAME_LO, 32'h0000_0000, NLO, 1'b0},
        '{rxm_pkg::IDX_NAME_MID, 32'h0000_0000, NMID, 1'b0},
        '{rxm_pkg::IDX_NAME_HI, 32'hFFFF_FFFF, {16'h0000, NHI}, 1'b0},
        '{rxm_pkg::IDX_MAX_LEN, 32'hFFFF_0044, 32'h0000_0044, 1'b0},
        '{rxm_pkg::IDX_CRC_FWD, 32'hFFFF_FFFF, 32'h0000_0001, 1'b0},
        '{rxm_pkg::IDX_FAULT, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
        '{rxm_pkg::IDX_RX_CTRL, 32'hFFFF_FFEF, 32'h0000_0000, 1'b0},
        '{rxm_pkg::IDX_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_001F, 1'b0},
        '{12'h505, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rxm_pkg::rxm_beat_t rx_in = '0;
    rxm_pkg::rxm_client_t rx_out;
    logic flt_loc = 1'b0;
    logic flt_rem = 1'b0;
    logic unidir = 1'b0;
    logic vlan_dis;
    logic irq;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    rxm_csr_bank #(.REV_ID(REV), .NAME_LO(NLO), .NAME_MID(NMID), .NAME_HI(NHI)) i_rxm_csr_bank (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_in(rx_in), .rx_out(rx_out), .fault_local_seen(flt_loc), .fault_remote_seen(flt_rem),
        .link_unidir_en(unidir), .vlan_detect_disable(vlan_dis), .irq(irq));
    rxm_client_model i_rxm_client_model (.clk(clk), .rx_out(rx_out));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        comparisons++;
        if (got !== ex) begin
            fails++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic apb(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] ex);
        apb(idx, 1'b0, 32'h0000_0000);
        chk(rd, ex);
    endtask
    task automatic chk_frame(input int n, input logic [3:0] e);
        chk(32'(i_rxm_client_model.beats), 32'(n));
        chk({28'h0, i_rxm_client_model.last_err}, {28'h0, e});
    endtask
    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
        for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ d[k]) ? rxm_pkg::CRC_POLY : 32'h0);
        return c;
    endfunction
    task automatic beat(input logic [7:0] d, input logic s, input logic e);
        @(posedge clk);
        rx_in <= '{valid: 1'b1, sop: s, eop: e, data: d};
    endtask
    // Payload n bytes; FCS goes out low byte first
    task automatic frame(input int n, input logic bad_fcs, input logic bad_pre);
        logic [31:0] c;
        c = rxm_pkg::CRC_INIT;
        i_rxm_client_model.beats = 0;
        i_rxm_client_model.last_err = 4'hF;
        beat(8'h55, 1'b1, 1'b0);
        for (int i = 1; i < 7; i++) beat((bad_pre && i == 3) ? 8'h57 : 8'h55, 1'b0, 1'b0);
        beat(rxm_pkg::SFD_BYTE, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            beat(i[7:0] ^ 8'h3C, 1'b0, 1'b0);
            c = crc_upd(c, i[7:0] ^ 8'h3C);
        end
        c = ~c ^ {31'h0, bad_fcs};
        for (int i = 0; i < 4; i++) beat(c[8*i +: 8], 1'b0, i == 3);
        @(posedge clk);
        rx_in <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic fault_case(input logic l, input logic r, input logic u, input logic [31:0] e);
        flt_loc <= l;
        flt_rem <= r;
        unidir <= u;
        repeat (4) @(posedge clk);
        rd_chk(rxm_pkg::IDX_FAULT, e);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[k]) begin
            apb(rows[k].idx, 1'b1, rows[k].wd);
            chk({31'h0, er}, {31'h0, rows[k].er});
            rd_chk(rows[k].idx, rows[k].ex);
        end
        chk({31'h0, vlan_dis}, 32'h1);
        $display("register table test done");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({31'h0, vlan_dis}, 32'h0);
        rd_chk(rxm_pkg::IDX_TX_CTRL, 32'h0);
        rd_chk(rxm_pkg::IDX_SCRATCH, 32'h0);
        rd_chk(rxm_pkg::IDX_MAX_LEN, 32'h2580);
        rd_chk(rxm_pkg::IDX_CRC_FWD, 32'h0);
        rd_chk(rxm_pkg::IDX_RX_CTRL, 32'h10);
        $display("reset value test done");
        frame(60, 1'b0, 1'b0);
        chk_frame(60, 4'h0);
        apb(rxm_pkg::IDX_CRC_FWD, 1'b1, 32'h1);
        frame(60, 1'b0, 1'b0);
        chk_frame(64, 4'h0);
        frame(60, 1'b1, 1'b0);
        chk_frame(64, 4'h2);
        apb(rxm_pkg::IDX_CRC_FWD, 1'b1, 32'h0);
        frame(60, 1'b1, 1'b0);
        chk_frame(60, 4'h2);
        apb(rxm_pkg::IDX_MAX_LEN, 1'b1, 32'h44);
        frame(64, 1'b0, 1'b0);
        chk_frame(64, 4'h0);
        frame(65, 1'b0, 1'b0);
        chk_frame(65, 4'h8);
        frame(60, 1'b0, 1'b1);
        chk_frame(60, 4'h1);
        apb(rxm_pkg::IDX_RX_CTRL, 1'b1, 32'h0);
        frame(60, 1'b0, 1'b1);
        chk_frame(60, 4'h0);
        $display("frame test done");
        chk({31'h0, irq}, 32'h0);
        apb(rxm_pkg::IDX_IRQ_MASK, 1'b1, 32'h2);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(rxm_pkg::IDX_IRQ_STAT, 1'b1, 32'h2);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        fault_case(1'b1, 1'b0, 1'b0, 32'h1);
        fault_case(1'b1, 1'b1, 1'b0, 32'h1);
        fault_case(1'b0, 1'b1, 1'b0, 32'h2);
        fault_case(1'b1, 1'b1, 1'b1, 32'h3);
        $display("fault test done");
        print_verdict();
    end
endmodule
